// >>> verilog/wde_params.svh
// Constants for the wake/enable deglitch and event block.
// Assumes a 20 MHz reference clock and a 32-bit Avalon-MM register bus.
`ifndef WDE_PARAMS_SVH
`define WDE_PARAMS_SVH

// Clock period in nanoseconds.
`define WDE_CLK_PERIOD_NS 50
// Qualification time (least) and reject time (longest), in microseconds.
`define WDE_QUALIFY_TIME_US 40
`define WDE_REJECT_TIME_US 20
// Qualification rounds up, rejection rounds down.
`define WDE_QUALIFY_CYCLES ((`WDE_QUALIFY_TIME_US * 1000 + `WDE_CLK_PERIOD_NS - 1) / `WDE_CLK_PERIOD_NS)
`define WDE_REJECT_CYCLES ((`WDE_REJECT_TIME_US * 1000) / `WDE_CLK_PERIOD_NS)
`define WDE_CNT_W 11

// Register byte addresses.
`define WDE_ADDR_CONFIG 4'h0
`define WDE_ADDR_STATUS 4'h4
`define WDE_ADDR_EVENT 4'h8
`define WDE_ADDR_MASK 4'hC
`define WDE_ADDR_CONTROL 4'h0

// Field positions.
`define WDE_CFG_MODE_BIT 0
`define WDE_STAT_LEVEL_BIT 0
`define WDE_STAT_FAULT_BIT 1
`define WDE_EVT_WAKE_BIT 0
`define WDE_CTRL_DISABLE_BIT 0

// Reset values.
`define WDE_CONFIG_RESET 1'h0
`define WDE_MASK_RESET 1'h0

`endif

// >>> verilog/wde_pkg.sv
// Types shared by the wake/enable deglitch block.
// Assumes the constants header is included by the modules.
package wde_pkg;

  // Trigger mode of the wake input.
  typedef enum logic {
    WDE_MODE_EDGE,
    WDE_MODE_LEVEL
  } wde_mode_e;

  // Power state of the device sequencer.
  typedef enum logic [1:0] {
    WDE_ST_DISABLED,
    WDE_ST_ACTIVE,
    WDE_ST_FAULT,
    WDE_ST_LOCKED
  } wde_state_e;

  // Requests passed from the wake logic to the state sequencer.
  typedef struct packed {
    logic wake;
    logic level_hold;
  } wde_req_s;

endpackage : wde_pkg

// >>> verilog/wde_filter.sv
// Duration filter for the synchronised wake comparator level.
// Assumes the input is already on the reference clock domain.
`timescale 1ns/100ps
`include "wde_params.svh"

module wde_filter
  import wde_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Raw level in, filtered level and edge pulses out.
  input wire logic i_raw,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);

  logic [`WDE_CNT_W-1:0] count;
  logic prev_raw;
  logic next_differs;
  logic next_done;

  // A level different from the filtered one must persist to be taken.
  assign next_differs = (i_raw != o_level);
  assign next_done = next_differs && (count == `WDE_CNT_W'(`WDE_QUALIFY_CYCLES - 1));

  // The counter restarts on any raw change so short pulses are discarded.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count <= '0;
      prev_raw <= 1'b0;
      o_level <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      prev_raw <= i_raw;
      o_rise <= next_done && i_raw;
      o_fall <= next_done && !i_raw;
      if (i_raw != prev_raw || !next_differs) begin
        count <= '0;
      end else if (next_done) begin
        count <= '0;
        o_level <= i_raw;
      end else begin
        count <= count + `WDE_CNT_W'(1);
      end
    end
  end

  // Short excursions never move the filtered level.
  chk_reject_short: assert property (@(posedge i_clk) disable iff (i_reset)
    $changed(o_level) |-> $past(i_raw, 2) == o_level) else $error("Filtered level changed without a held input.");
  chk_count_bound: assert property (@(posedge i_clk) disable iff (i_reset)
    count < `WDE_CNT_W'(`WDE_QUALIFY_CYCLES)) else $error("Qualify counter exceeded its limit.");

endmodule : wde_filter

// >>> verilog/wde_top.sv
// Wake/enable input deglitch, event detection and power-state sequencing.
// Assumes an asynchronous wake pin and an Avalon-MM master on I_REF_CLK.
//
// Function
// - The wake input is a level qualified by duration, high meaning enabled.
// - A new high level is taken only after 40 us of continuous high input.
// - A high excursion under 20 us leaves the filtered level unchanged.
// - A new low level is taken only after 40 us of continuous low input.
// - A low dip under 20 us leaves the filtered level high.
// - The filtered level is readable in a read-only status bit.
// - A qualified rise or fall of the filtered level is an enable event.
// - Each enable event sets a sticky wake event flag for software.
// - A rise, and in level mode also a fall, is passed to the state machine, which may power up.
// - An enable event never shuts the device down; software must request that.
// - After reset the input is edge triggered, only a rise waking the device.
// - Software selects edge or level mode in the configuration register.
// - In level mode a high filtered level returns the device from fault to active.
// - In level mode with a high level the device never locks after three faults.
// - A disable request through the control pair restores the configuration defaults.
`timescale 1ns/100ps
`include "wde_params.svh"

module wde_top
  import wde_pkg::*;
(
  // Clock and reset.
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // Wake pin and fault reports from the power stage.
  input wire logic I_WAKE_ENABLE_INPUT,
  input wire logic I_FAULT,
  // Avalon-MM slave.
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Interrupt and state outputs.
  output logic O_IRQ,
  output logic O_POWER_ON,
  output logic [1:0] O_STATE
);

  logic sync_a;
  logic sync_b;
  logic filt_level;
  logic filt_rise;
  logic filt_fall;
  logic wake_event_flag;
  logic wake_event_mask;
  wde_mode_e wake_trigger_mode_select;
  wde_state_e state;
  wde_state_e next_state;
  logic [1:0] fault_count;
  logic fault_seen;
  logic acc_done;
  wde_req_s req;

  // Two flip-flops bring the pin onto the clock domain.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= I_WAKE_ENABLE_INPUT;
      sync_b <= sync_a;
    end
  end

  // Duration filter.
  wde_filter u_filter (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_raw(sync_b),
    .o_level(filt_level),
    .o_rise(filt_rise),
    .o_fall(filt_fall)
  );

  // Register address match, shared by every select line below.
  function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] offset);
    logic hit;
    hit = (addr == offset);
    return hit;
  endfunction : addr_hit

  // Bus decode; every access answers one cycle after it is seen.
  logic sel_config;
  logic sel_status;
  logic sel_event;
  logic sel_mask;
  logic sel_control;
  logic acc;
  logic wr_go;
  logic event_any;
  logic clear_event;
  logic disable_req;
  assign acc = (I_AVS_READ || I_AVS_WRITE) && !acc_done;
  assign wr_go = I_AVS_WRITE && acc_done;
  assign sel_config = addr_hit(I_AVS_ADDRESS, `WDE_ADDR_CONFIG);
  assign sel_status = addr_hit(I_AVS_ADDRESS, `WDE_ADDR_STATUS);
  assign sel_event = addr_hit(I_AVS_ADDRESS, `WDE_ADDR_EVENT);
  assign sel_mask = addr_hit(I_AVS_ADDRESS, `WDE_ADDR_MASK);
  // The control pair shares the configuration word, so its select matches the same offset.
  assign sel_control = addr_hit(I_AVS_ADDRESS, `WDE_ADDR_CONTROL);
  assign event_any = filt_rise || filt_fall;
  assign clear_event = wr_go && sel_event && I_AVS_WRITEDATA[`WDE_EVT_WAKE_BIT];
  // The configuration word also carries the disable command in bit 1.
  assign disable_req = wr_go && sel_control && I_AVS_WRITEDATA[1];

  // Wake requests for the sequencer, chosen by the trigger mode.
  assign req.wake = (wake_trigger_mode_select == WDE_MODE_EDGE) ? filt_rise : (filt_rise || filt_fall);
  assign req.level_hold = (wake_trigger_mode_select == WDE_MODE_LEVEL) && filt_level;

  // Wait state generation: waitrequest drops one cycle after the request.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      acc_done <= 1'b0;
      O_AVS_WAITREQUEST <= 1'b1;
    end else begin
      acc_done <= acc;
      O_AVS_WAITREQUEST <= !acc;
    end
  end

  // Read data, captured while waitrequest is still high.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      O_AVS_READDATA <= 32'h00000000;
    end else if (acc && I_AVS_READ) begin
      if (sel_config) begin
        O_AVS_READDATA <= {31'h00000000, wake_trigger_mode_select};
      end else if (sel_status) begin
        O_AVS_READDATA <= {30'h00000000, state == WDE_ST_FAULT, filt_level};
      end else if (sel_event) begin
        O_AVS_READDATA <= {31'h00000000, wake_event_flag};
      end else if (sel_mask) begin
        O_AVS_READDATA <= {31'h00000000, wake_event_mask};
      end else begin
        O_AVS_READDATA <= 32'h00000000;
      end
    end
  end

  // Configuration and mask registers; a disable resets the configuration.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      wake_trigger_mode_select <= WDE_MODE_EDGE;
      wake_event_mask <= `WDE_MASK_RESET;
    end else begin
      if (disable_req) begin
        wake_trigger_mode_select <= WDE_MODE_EDGE;
      end else if (wr_go && sel_config) begin
        wake_trigger_mode_select <= wde_mode_e'(I_AVS_WRITEDATA[`WDE_CFG_MODE_BIT]);
      end
      if (wr_go && sel_mask) begin
        wake_event_mask <= I_AVS_WRITEDATA[`WDE_EVT_WAKE_BIT];
      end
    end
  end

  // Sticky event flag; a new event wins over a clear in the same cycle.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      wake_event_flag <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      wake_event_flag <= event_any || (wake_event_flag && !clear_event);
      O_IRQ <= (event_any || (wake_event_flag && !clear_event)) && wake_event_mask;
    end
  end

  // Sequencer: three faults lock unless level mode holds the input high.
  always_comb begin
    next_state = state;
    case (state)
      WDE_ST_DISABLED: begin
        if (req.wake) begin
          next_state = WDE_ST_ACTIVE;
        end
      end
      WDE_ST_ACTIVE: begin
        if (disable_req) begin
          next_state = WDE_ST_DISABLED;
        end else if (I_FAULT) begin
          next_state = WDE_ST_FAULT;
        end
      end
      WDE_ST_FAULT: begin
        if (disable_req) begin
          next_state = WDE_ST_DISABLED;
        end else if (req.level_hold) begin
          next_state = WDE_ST_ACTIVE;
        end else if (fault_count == 2'h3) begin
          next_state = WDE_ST_LOCKED;
        end else if (req.wake) begin
          next_state = WDE_ST_ACTIVE;
        end
      end
      default: begin
        if (disable_req) begin
          next_state = WDE_ST_DISABLED;
        end
      end
    endcase
  end

  // State register and fault counter, cleared only by reset or a move to the disabled state.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      state <= WDE_ST_DISABLED;
      fault_count <= 2'h0;
      fault_seen <= 1'b0;
      O_POWER_ON <= 1'b0;
      O_STATE <= 2'h0;
    end else begin
      state <= next_state;
      fault_seen <= (state == WDE_ST_ACTIVE) && (next_state == WDE_ST_FAULT);
      if (next_state == WDE_ST_DISABLED) begin
        fault_count <= 2'h0;
      end else if ((state == WDE_ST_ACTIVE) && (next_state == WDE_ST_FAULT) && fault_count != 2'h3) begin
        fault_count <= fault_count + 2'h1;
      end
      O_POWER_ON <= (next_state == WDE_ST_ACTIVE);
      O_STATE <= next_state;
    end
  end

  // Checks.
  chk_event_sets_flag: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    event_any |=> wake_event_flag) else $error("Event did not set the flag.");
  chk_edge_mode_fall: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == WDE_ST_DISABLED && wake_trigger_mode_select == WDE_MODE_EDGE && filt_fall && !filt_rise)
    |=> state == WDE_ST_DISABLED) else $error("Fall woke device in edge mode.");
  chk_no_event_shutdown: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == WDE_ST_ACTIVE && !disable_req) |=> state != WDE_ST_DISABLED) else $error("Device shut down by itself.");
  chk_level_no_lock: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == WDE_ST_FAULT && req.level_hold && !disable_req) |=> state == WDE_ST_ACTIVE)
    else $error("Level mode did not return to active.");
  chk_disable_defaults: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    disable_req |=> wake_trigger_mode_select == WDE_MODE_EDGE) else $error("Config not restored.");
  chk_rise_wakes: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == WDE_ST_DISABLED && filt_rise) |=> state == WDE_ST_ACTIVE) else $error("Rise did not wake.");
  chk_status_level: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (acc && I_AVS_READ && sel_status) |=> O_AVS_READDATA[0] == $past(filt_level)) else $error("Bad status level.");
  chk_mode_applied: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (wr_go && sel_config && !I_AVS_WRITEDATA[1]) |=> wake_trigger_mode_select == $past(I_AVS_WRITEDATA[0]))
    else $error("Mode write not applied.");
  chk_qualify_hold: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    filt_rise |-> $past(sync_b, 1) && $past(sync_b, 8)) else $error("Rise without held input.");
  chk_fall_hold: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    filt_fall |-> !$past(sync_b, 1) && !$past(sync_b, 8)) else $error("Fall without held input.");
  chk_level_event: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    $changed(filt_level) |-> (filt_rise || filt_fall)) else $error("Level moved without an event.");

  // The interrupt follows the flag and the mask of the previous cycle.
  chk_irq_level: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    O_IRQ == (wake_event_flag && $past(wake_event_mask))) else $error("Interrupt does not follow the flag.");

  // A new event wins over a clear in the same cycle, so no event is lost.
  chk_flag_set_wins: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (event_any && clear_event) |=> wake_event_flag) else $error("Clear beat a new event.");

  // A clear without a new event drops the flag.
  chk_clear_flag: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (clear_event && !event_any) |=> !wake_event_flag) else $error("Flag not cleared.");

  // Mask writes land at the edge that completes the access.
  chk_mask_write: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (wr_go && sel_mask) |=> wake_event_mask == $past(I_AVS_WRITEDATA[0])) else $error("Mask write lost.");

  // Every access gets exactly one wait state.
  chk_wait_one: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    acc |=> !O_AVS_WAITREQUEST) else $error("Access not answered.");

  // Waitrequest is low for one cycle only, so a held strobe is not taken twice.
  chk_wait_single: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST) else $error("Waitrequest low too long.");

  // Unmapped addresses read as zero.
  chk_read_unmapped: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (acc && I_AVS_READ && !(sel_config || sel_status || sel_event || sel_mask)) |=> O_AVS_READDATA == 32'h00000000)
    else $error("Unmapped read not zero.");

  // The second stage only ever copies the first.
  chk_sync_stage: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    sync_b == $past(sync_a)) else $error("Synchroniser skipped a stage.");

  // Power output mirrors the active state.
  chk_power_matches: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    O_POWER_ON == (state == WDE_ST_ACTIVE)) else $error("Power output disagrees with state.");

  // State output mirrors the state register.
  chk_state_out: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    O_STATE == state) else $error("State output disagrees with state.");

  // A fault in the active state moves to the fault state unless a disable request comes in the same cycle.
  chk_fault_entry: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == WDE_ST_ACTIVE && I_FAULT && !disable_req) |=> state == WDE_ST_FAULT) else $error("Fault ignored.");

  // Each fault entry is counted, the count saturating at three.
  chk_fault_count: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    fault_seen |-> fault_count != 2'h0) else $error("Fault entry not counted.");

  // Locking needs three counted faults and no level hold.
  chk_lock_entry: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    $rose(state == WDE_ST_LOCKED) |-> ($past(fault_count) == 2'h3 && !$past(req.level_hold)))
    else $error("Locked too early.");

  // Only a disable request leaves the locked state.
  chk_locked_holds: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == WDE_ST_LOCKED && !disable_req) |=> state == WDE_ST_LOCKED) else $error("Left locked state.");

  // In edge mode the fault state waits for a fresh rise.
  chk_edge_fault_waits: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == WDE_ST_FAULT && wake_trigger_mode_select == WDE_MODE_EDGE && !req.wake && !disable_req
     && fault_count != 2'h3) |=> state == WDE_ST_FAULT) else $error("Fault state left without a rise.");

  // In level mode a fall wakes the device as well.
  chk_level_fall_wakes: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == WDE_ST_DISABLED && wake_trigger_mode_select == WDE_MODE_LEVEL && filt_fall)
    |=> state == WDE_ST_ACTIVE) else $error("Fall did not wake in level mode.");

endmodule : wde_top

// >>> sim/wde_wake_src.sv
// Wake source model: a push-pull wake line from a transceiver or an ECU pin.
// Assumes the bench calls drive() from its own clocked sequence.
`timescale 1ns/100ps

module wde_wake_src (
  // Clock in.
  input wire logic i_clk,
  // Wake line out.
  output logic o_wake
);
  // The line is always driven, so it never floats between commands.
  initial o_wake = 1'b0;

  // Set a level just after an edge, then hold it for a number of cycles.
  task automatic drive(input logic lvl, input int cycles);
    @(posedge i_clk);
    o_wake <= lvl;
    repeat (cycles) @(posedge i_clk);
  endtask : drive
endmodule : wde_wake_src

// >>> sim/wde_top_bench.sv
// Self-checking bench for the wake deglitch, event and sequencing block.
// Assumes the wake source model and the design files are compiled first.
`timescale 1ns/100ps
`include "wde_params.svh"

module wde_top_bench
  import wde_pkg::*;
;
  localparam logic [3:0] a_cfg = `WDE_ADDR_CONFIG;
  localparam logic [3:0] a_sts = `WDE_ADDR_STATUS;
  localparam logic [3:0] a_evt = `WDE_ADDR_EVENT;
  localparam logic [3:0] a_msk = `WDE_ADDR_MASK;
  localparam int rej = `WDE_REJECT_CYCLES;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fault = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic irq;
  logic pwr;
  logic [1:0] state;
  logic wake;
  int error_cnt = 0;
  int samples_checked = 0;

  // Free-running 20 MHz clock.
  always #25 clk = ~clk;

  wde_wake_src src (.i_clk(clk), .o_wake(wake));

  wde_top uut (
    .I_REF_CLK(clk), .I_RESET(rst), .I_WAKE_ENABLE_INPUT(wake), .I_FAULT(fault),
    .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_req), .O_IRQ(irq),
    .O_POWER_ON(pwr), .O_STATE(state)
  );

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One Avalon access, held until waitrequest is sampled low.
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= ~we;
    wr <= we;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_req !== 1'b0) begin
      error_cnt++;
      wrap_up();
    end
  endtask : bus

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd_chk

  // Reset values, and an unmapped address that reads zero and ignores writes.
  task automatic t_reset();
    rd_chk(a_cfg, 32'h0);
    rd_chk(a_sts, 32'h0);
    rd_chk(a_evt, 32'h0);
    rd_chk(a_msk, 32'h0);
    wr_reg(4'h2, 32'hFFFFFFFF);
    rd_chk(4'h2, 32'h0);
    chk({30'h0, state}, {30'h0, WDE_ST_DISABLED});
  endtask : t_reset

  // Short high pulses; the split one spans more than the qualify time in total.
  task automatic t_glitch();
    src.drive(1'b1, rej - 10);
    src.drive(1'b0, 5);
    src.drive(1'b1, 500);
    src.drive(1'b0, 900);
    chk({31'h0, pwr}, 32'h0);
    rd_chk(a_sts, 32'h0);
    rd_chk(a_evt, 32'h0);
  endtask : t_glitch

  // Qualified rise wakes the device; the flag drives the interrupt when unmasked.
  task automatic t_wake();
    int n;
    src.drive(1'b1, 0);
    n = 0;
    while (pwr !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= 800}, 32'h1);
    chk({31'h0, n <= 806}, 32'h1);
    rd_chk(a_sts, 32'h1);
    rd_chk(a_evt, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr_reg(a_msk, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr_reg(a_evt, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(a_evt, 32'h0);
  endtask : t_wake

  // Short low dips leave the filtered level high.
  task automatic t_dip();
    src.drive(1'b0, rej - 10);
    src.drive(1'b1, 5);
    src.drive(1'b0, 500);
    src.drive(1'b1, 900);
    rd_chk(a_sts, 32'h1);
    rd_chk(a_evt, 32'h0);
  endtask : t_dip

  // A qualified fall is an event but leaves the device powered.
  task automatic t_fall();
    src.drive(1'b0, 780);
    rd_chk(a_sts, 32'h1);
    repeat (40) @(posedge clk);
    rd_chk(a_sts, 32'h0);
    rd_chk(a_evt, 32'h1);
    chk({31'h0, pwr}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr_reg(a_evt, 32'h1);
  endtask : t_fall

  // Level mode with the pin high: four faults in a row never lock the device.
  task automatic t_level();
    int n;
    logic seen;
    wr_reg(a_cfg, 32'h1);
    rd_chk(a_cfg, 32'h1);
    src.drive(1'b1, 900);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) fault <= 1'b1;
      @(posedge clk) fault <= 1'b0;
      seen = 1'b0;
      n = 0;
      while (!(seen && state === WDE_ST_ACTIVE) && n < 30) begin
        @(posedge clk);
        n++;
        if (state === WDE_ST_FAULT) seen = 1'b1;
      end
      chk({31'h0, seen}, 32'h1);
      chk({30'h0, state}, {30'h0, WDE_ST_ACTIVE});
    end
  endtask : t_level

  // Disable request restores edge mode, so only a rise wakes again.
  task automatic t_disable();
    wr_reg(a_cfg, 32'h2);
    repeat (2) @(posedge clk);
    chk({30'h0, state}, {30'h0, WDE_ST_DISABLED});
    rd_chk(a_cfg, 32'h0);
    src.drive(1'b0, 900);
    chk({30'h0, state}, {30'h0, WDE_ST_DISABLED});
    rd_chk(a_evt, 32'h1);
    src.drive(1'b1, 900);
    chk({31'h0, pwr}, 32'h1);
  endtask : t_disable

  // Edge mode: each fault waits for a fresh rise, and the third one locks the device.
  task automatic t_lock();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) fault <= 1'b1;
      @(posedge clk) fault <= 1'b0;
      repeat (3) @(posedge clk);
      if (k < 2) begin
        chk({30'h0, state}, {30'h0, WDE_ST_FAULT});
        rd_chk(a_sts, 32'h3);
        src.drive(1'b0, 900);
        src.drive(1'b1, 900);
        chk({30'h0, state}, {30'h0, WDE_ST_ACTIVE});
      end
    end
    chk({30'h0, state}, {30'h0, WDE_ST_LOCKED});
  endtask : t_lock

  // Main sequence: reset for 16 cycles, then each scenario in turn.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_glitch();
    t_wake();
    t_dip();
    t_fall();
    t_level();
    t_disable();
    t_lock();
    wrap_up();
  end
endmodule : wde_top_bench
